// ===== core/gpa_port.sv
/*
 general purpose pin port top: register file, input sampling, pin
 drive and alternate routing. assumes a single-cycle register master
 and a bench that resolves each pin wire from pin_o and pin_oe_n.
*/
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module gpa_port #(
   parameter int SAMPLE_CYCLES = gpa_pkg::SAMPLE_CYCLES
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // register port
   input wire logic [gpa_pkg::ADDR_W-1:0] addr_i,
   input wire logic [gpa_pkg::REG_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [gpa_pkg::REG_W-1:0] rdata_o,
   // pins
   input wire logic [gpa_pkg::PIN_COUNT-1:0] pin_i,
   output logic [gpa_pkg::PIN_COUNT-1:0] pin_o,
   output logic [gpa_pkg::PIN_COUNT-1:0] pin_oe_n_o,
   // core-side alternate outputs
   input wire logic [gpa_pkg::PART_COUNT-1:0] partition_drive_n_i,
   input wire logic general_event_out_n_i,
   input wire logic [gpa_pkg::HP_GROUPS-1:0] slot_attention_indicator_n_i,
   input wire logic [gpa_pkg::HP_GROUPS-1:0] slot_power_indicator_n_i,
   input wire logic [gpa_pkg::HP_GROUPS-1:0] slot_power_enable_i,
   input wire logic [gpa_pkg::HP_GROUPS-1:0] slot_reset_n_i,
   input wire logic [gpa_pkg::LINK_PORTS-1:0] port_link_up_i,
   input wire logic [gpa_pkg::LINK_PORTS-1:0] port_link_active_i,
   // expander-supplied slot inputs
   input wire logic [gpa_pkg::HP_GROUPS-1:0] exp_slot_en_i,
   input wire logic [gpa_pkg::HP_GROUPS*5-1:0] exp_slot_in_n_i,
   // core-side alternate inputs
   output logic [gpa_pkg::PART_COUNT-1:0] partition_reset_n_o,
   output logic expander_interrupt_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_attention_button_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_presence_detect_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_power_fault_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_power_good_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_retention_latch_n_o
);
   import gpa_pkg::*;

   localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

   // below the package figure the spacing breaks the minimum interval
   if (SAMPLE_CYCLES < gpa_pkg::SAMPLE_CYCLES ||
       SAMPLE_CYCLES > (1 << CNT_W)) begin : g_chk
      $error("gpa_port sample interval too short or too long for counter");
   end

   // pin_function_select, pin_direction_config, pin_data,
   // pin_alternate_select: one bit per pin each
   logic [PIN_COUNT-1:0] func_r, func_nxt;
   logic [PIN_COUNT-1:0] dir_r, dir_nxt;
   logic [PIN_COUNT-1:0] data_r, data_nxt;
   logic [PIN_COUNT-1:0] alt_r, alt_nxt;
   logic [PIN_COUNT-1:0] sample_r, sample_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [REG_W-1:0] rdata_r, rdata_nxt;
   logic [PIN_COUNT-1:0] pin_o_r, pin_o_nxt;
   logic [PIN_COUNT-1:0] oe_n_r, oe_n_nxt;
   logic [PART_COUNT-1:0] part_r, part_nxt;
   logic expint_r, expint_nxt;
   logic [HP_GROUPS-1:0] btn_r, btn_nxt;
   logic [HP_GROUPS-1:0] pres_r, pres_nxt;
   logic [HP_GROUPS-1:0] flt_r, flt_nxt;
   logic [HP_GROUPS-1:0] good_r, good_nxt;
   logic [HP_GROUPS-1:0] latch_r, latch_nxt;
   logic [PIN_COUNT-1:0] sync_q;
   logic [PIN_COUNT-1:0] alt_val;
   logic [PIN_COUNT-1:0] alt_oe;
   logic [PIN_COUNT-1:0] out_mask;
   logic [PIN_COUNT-1:0] in_mask;
   logic tick;

   function automatic logic [PIN_COUNT-1:0] wr_half(
      input logic [PIN_COUNT-1:0] cur, input logic [REG_W-1:0] wd,
      input logic hi);
      logic [PIN_COUNT-1:0] r;
      r = cur;
      if (hi) begin
         r[PIN_COUNT-1:LO_PINS] = wd[HI_PINS-1:0];
      end else begin
         r[LO_PINS-1:0] = wd;
      end
      return r;
   endfunction

   function automatic logic [REG_W-1:0] rd_half(
      input logic [PIN_COUNT-1:0] v, input logic hi);
      logic [REG_W-1:0] r;
      r = RDATA_RST;
      if (hi) begin
         r[HI_PINS-1:0] = v[PIN_COUNT-1:LO_PINS];
      end else begin
         r = v[LO_PINS-1:0];
      end
      return r;
   endfunction

   // asynchronous pins cross here before anything looks at them
   gpa_sync #(.WIDTH(PIN_COUNT)) u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .d_i(pin_i),
      .q_o(sync_q)
   );

   gpa_alt_map u_map (
      .func_i(func_r),
      .alt_sel_i(alt_r),
      .level_i(sample_r),
      .partition_drive_n_i(partition_drive_n_i),
      .general_event_out_n_i(general_event_out_n_i),
      .slot_attention_indicator_n_i(slot_attention_indicator_n_i),
      .slot_power_indicator_n_i(slot_power_indicator_n_i),
      .slot_power_enable_i(slot_power_enable_i),
      .slot_reset_n_i(slot_reset_n_i),
      .port_link_up_i(port_link_up_i),
      .port_link_active_i(port_link_active_i),
      .exp_slot_en_i(exp_slot_en_i),
      .exp_slot_in_n_i(exp_slot_in_n_i),
      .alt_val_o(alt_val),
      .alt_oe_o(alt_oe),
      .partition_reset_n_o(part_nxt),
      .expander_interrupt_n_o(expint_nxt),
      .slot_attention_button_n_o(btn_nxt),
      .slot_presence_detect_n_o(pres_nxt),
      .slot_power_fault_n_o(flt_nxt),
      .slot_power_good_n_o(good_nxt),
      .slot_retention_latch_n_o(latch_nxt)
   );

   // sample tick: spacing never shorter than the minimum interval
   always_comb begin
      tick = (cnt_r == SAMPLE_LAST);
      cnt_nxt = tick ? CNT_ZERO : cnt_r + CNT_ONE;
      sample_nxt = tick ? sync_q : sample_r;
   end

   // registers; in software input mode the captured level wins over a
   // write in the same cycle
   always_comb begin
      func_nxt = func_r;
      dir_nxt = dir_r;
      data_nxt = data_r;
      alt_nxt = alt_r;
      rdata_nxt = rdata_r;
      if (wr_i) begin
         unique case (addr_i)
            OFF_FUNC_LO: func_nxt = wr_half(func_r, wdata_i, 1'b0);
            OFF_FUNC_HI: func_nxt = wr_half(func_r, wdata_i, 1'b1);
            OFF_DIR_LO: dir_nxt = wr_half(dir_r, wdata_i, 1'b0);
            OFF_DIR_HI: dir_nxt = wr_half(dir_r, wdata_i, 1'b1);
            OFF_DATA_LO: data_nxt = wr_half(data_r, wdata_i, 1'b0);
            OFF_DATA_HI: data_nxt = wr_half(data_r, wdata_i, 1'b1);
            OFF_ALT_LO: alt_nxt = wr_half(alt_r, wdata_i, 1'b0);
            OFF_ALT_HI: alt_nxt = wr_half(alt_r, wdata_i, 1'b1);
            default: ;
         endcase
      end
      if (tick) begin
         data_nxt = (data_nxt & ~in_mask) | (sync_q & in_mask);
      end
      if (rd_i) begin
         unique case (addr_i)
            OFF_FUNC_LO: rdata_nxt = rd_half(func_r, 1'b0);
            OFF_FUNC_HI: rdata_nxt = rd_half(func_r, 1'b1);
            OFF_DIR_LO: rdata_nxt = rd_half(dir_r, 1'b0);
            OFF_DIR_HI: rdata_nxt = rd_half(dir_r, 1'b1);
            OFF_DATA_LO: rdata_nxt = rd_half(sample_r, 1'b0);
            OFF_DATA_HI: rdata_nxt = rd_half(sample_r, 1'b1);
            OFF_ALT_LO: rdata_nxt = rd_half(alt_r, 1'b0);
            OFF_ALT_HI: rdata_nxt = rd_half(alt_r, 1'b1);
            default: rdata_nxt = RDATA_RST;
         endcase
      end else begin
         rdata_nxt = RDATA_RST;
      end
   end

   // per-pin drive
   always_comb begin
      pin_o_nxt = PIN_ZERO;
      oe_n_nxt = ~PIN_ZERO;
      out_mask = PIN_ZERO;
      in_mask = PIN_ZERO;
      for (int p = 0; p < PIN_COUNT; p++) begin
         unique case (pin_mode(func_r[p], dir_r[p]))
            GPA_SW_IN: begin
               in_mask[p] = 1'b1;
            end
            GPA_SW_OUT: begin
               out_mask[p] = 1'b1;
               pin_o_nxt[p] = data_r[p];
               oe_n_nxt[p] = 1'b0;
            end
            GPA_ALT: begin
               pin_o_nxt[p] = alt_val[p];
               oe_n_nxt[p] = ~alt_oe[p];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         func_r <= FUNC_RST;
         dir_r <= DIR_RST;
         data_r <= DATA_RST;
         alt_r <= ALT_RST;
         sample_r <= PIN_ZERO;
         cnt_r <= CNT_ZERO;
         rdata_r <= RDATA_RST;
         pin_o_r <= PIN_ZERO;
         oe_n_r <= ~PIN_ZERO;
         part_r <= '1;
         expint_r <= 1'b1;
         btn_r <= '1;
         pres_r <= '1;
         flt_r <= '1;
         good_r <= '1;
         latch_r <= '1;
      end else begin
         func_r <= func_nxt;
         dir_r <= dir_nxt;
         data_r <= data_nxt;
         alt_r <= alt_nxt;
         sample_r <= sample_nxt;
         cnt_r <= cnt_nxt;
         rdata_r <= rdata_nxt;
         pin_o_r <= pin_o_nxt;
         oe_n_r <= oe_n_nxt;
         part_r <= part_nxt;
         expint_r <= expint_nxt;
         btn_r <= btn_nxt;
         pres_r <= pres_nxt;
         flt_r <= flt_nxt;
         good_r <= good_nxt;
         latch_r <= latch_nxt;
      end
   end

   assign rdata_o = rdata_r;
   assign pin_o = pin_o_r;
   assign pin_oe_n_o = oe_n_r;
   assign partition_reset_n_o = part_r;
   assign expander_interrupt_n_o = expint_r;
   assign slot_attention_button_n_o = btn_r;
   assign slot_presence_detect_n_o = pres_r;
   assign slot_power_fault_n_o = flt_r;
   assign slot_power_good_n_o = good_r;
   assign slot_retention_latch_n_o = latch_r;

   a_reset_all_input: assert property (
      @(posedge clock_i) $fell(rst_i) |-> pin_oe_n_o == ~PIN_ZERO)
      else $error("pins not released after reset");

   a_sample_spacing: assert property (
      @(posedge clock_i) disable iff (rst_i)
      tick |=> !tick [*5])
      else $error("pin sample taken too soon");

   a_input_capture: assert property (
      @(posedge clock_i) disable iff (rst_i)
      tick |=> ((data_r ^ $past(sync_q)) & $past(in_mask)) == PIN_ZERO)
      else $error("input level not captured into data");

   a_data_read_level: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (rd_i && addr_i == OFF_DATA_HI) |=>
         rdata_o == rd_half($past(sample_r), 1'b1))
      else $error("data read does not show pin level");

   a_sw_output_drive: assert property (
      @(posedge clock_i) disable iff (rst_i)
      out_mask != PIN_ZERO |=>
         ((pin_o ^ $past(data_r)) & $past(out_mask)) == PIN_ZERO
         && (pin_oe_n_o & $past(out_mask)) == PIN_ZERO)
      else $error("output pin not driven from data");

   a_input_undriven: assert property (
      @(posedge clock_i) disable iff (rst_i)
      1'b1 |=> (~pin_oe_n_o &
         $past(in_mask | (func_r & ~alt_oe))) == PIN_ZERO)
      else $error("input pin is being driven");

   a_unmapped_held: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !(func_r[0] && !alt_r[0]) |=> partition_reset_n_o[0])
      else $error("unmapped partition reset not held high");

   a_gpe_on_pin: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (func_r[GPE_PIN] && !alt_r[GPE_PIN]) |=>
         !pin_oe_n_o[GPE_PIN] &&
         pin_o[GPE_PIN] == $past(general_event_out_n_i))
      else $error("general event not on its pin");

   a_link_active_low: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (func_r[LINK_BASE_PIN] && alt_r[LINK_BASE_PIN]) |=>
         !pin_oe_n_o[LINK_BASE_PIN] &&
         pin_o[LINK_BASE_PIN] == !$past(port_link_up_i[1]))
      else $error("link-up pin not active low");

   a_high_half_write: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (wr_i && addr_i == OFF_FUNC_HI) |=>
         func_r[PIN_COUNT-1:LO_PINS] == $past(wdata_i[HI_PINS-1:0]))
      else $error("high register write misplaced");
endmodule // gpa_port

// ===== core/gpa_pkg.sv
/*
 constants, pin mode decode and alternate-function pin map for the
 general purpose pin port. assumes one 40 MHz core clock.
*/
// Contract
// - 54 pins, each input, output or alternate
// - after reset every pin is software input
// - inputs double-synchronised, sampled at least 128 ns apart
// - one function, direction, data bit per pin
// - function 0 uses direction; function 1 alternate
// - software input pin level captured into data
// - data read returns actual pin level always
// - software output drives the data bit
// - alternate select bit picks function 0 or 1
// - alternate pin direction follows selected signal
// - unmapped alternate inputs held at inactive level; unmapped slot inputs of a group with exp_slot_en_i set follow the expander
// - fixed alternate function to pin mapping
// - slot button/presence/fault/good/latch in, rest out
// - partition reset is bidirectional, active low
// - link-up and link-active pins driven active low
package gpa_pkg;
   localparam int PIN_COUNT = 54;
   localparam int LO_PINS = 32;
   localparam int HI_PINS = 22;
   localparam int REG_W = 32;
   localparam int ADDR_W = 5;

   localparam logic [ADDR_W-1:0] OFF_FUNC_LO = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_FUNC_HI = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_DIR_LO = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_DIR_HI = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_DATA_LO = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_DATA_HI = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_ALT_LO = 5'h18;
   localparam logic [ADDR_W-1:0] OFF_ALT_HI = 5'h1C;

   localparam logic [PIN_COUNT-1:0] PIN_ZERO = 54'h00_0000_0000_0000;
   localparam logic [PIN_COUNT-1:0] FUNC_RST = PIN_ZERO;
   localparam logic [PIN_COUNT-1:0] DIR_RST = PIN_ZERO;
   localparam logic [PIN_COUNT-1:0] DATA_RST = PIN_ZERO;
   localparam logic [PIN_COUNT-1:0] ALT_RST = PIN_ZERO;
   localparam logic [REG_W-1:0] RDATA_RST = 32'h0000_0000;

   localparam int CLK_MHZ = 40;
   localparam int SAMPLE_NS = 128;
   // least interval: round up to whole cycles
   localparam int SAMPLE_CYCLES = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 3;

   localparam int PART_COUNT = 4;
   localparam int GPE_PIN = 5;
   localparam int EXPINT_PIN = 8;
   localparam int HP_GROUPS = 5;
   localparam int HP_BASE = 9;
   localparam int HP_GROUP_PINS = 9;
   localparam int HP_IN_COUNT = 5;
   localparam int HP_AI_OFF = 5;
   localparam int HP_PI_OFF = 6;
   localparam int HP_PEP_OFF = 7;
   localparam int LINK_PORTS = 16;
   localparam int P0_UP_PIN = 4;
   localparam int P0_ACT_PIN = 5;
   localparam int LINK_BASE_PIN = 22;
   localparam int LINK_LAST_PIN = 51;

   typedef enum logic [1:0] {
      GPA_SW_IN = 2'b00,
      GPA_SW_OUT = 2'b01,
      GPA_ALT = 2'b10
   } gpa_mode_t;

   function automatic gpa_mode_t pin_mode(input logic func,
                                          input logic dir);
      if (func) begin
         return GPA_ALT;
      end
      return dir ? GPA_SW_OUT : GPA_SW_IN;
   endfunction
endpackage

// ===== core/gpa_sync.sv
/*
 two-stage level synchroniser for a bus of independent pin levels.
 assumes each bit is asynchronous on its own; no bus coherence.
*/
`timescale 1ns/1ps
module gpa_sync #(
   parameter int WIDTH = 54
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // levels
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   if (WIDTH < 1) begin : g_chk
      $error("gpa_sync width must be positive");
   end

   always_comb begin
      meta_nxt = d_i;
      q_nxt = meta_r; // meta_r feeds only this stage
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;
endmodule // gpa_sync

// ===== core/gpa_alt_map.sv
/*
 fixed alternate-function routing: per-pin alternate drive value and
 drive enable, and the core-facing alternate inputs.
 assumes levels already synchronised and sampled.
*/
`timescale 1ns/1ps
module gpa_alt_map (
   // pin configuration and sampled levels
   input wire logic [gpa_pkg::PIN_COUNT-1:0] func_i,
   input wire logic [gpa_pkg::PIN_COUNT-1:0] alt_sel_i,
   input wire logic [gpa_pkg::PIN_COUNT-1:0] level_i,
   // core-side alternate outputs
   input wire logic [gpa_pkg::PART_COUNT-1:0] partition_drive_n_i,
   input wire logic general_event_out_n_i,
   input wire logic [gpa_pkg::HP_GROUPS-1:0] slot_attention_indicator_n_i,
   input wire logic [gpa_pkg::HP_GROUPS-1:0] slot_power_indicator_n_i,
   input wire logic [gpa_pkg::HP_GROUPS-1:0] slot_power_enable_i,
   input wire logic [gpa_pkg::HP_GROUPS-1:0] slot_reset_n_i,
   input wire logic [gpa_pkg::LINK_PORTS-1:0] port_link_up_i,
   input wire logic [gpa_pkg::LINK_PORTS-1:0] port_link_active_i,
   // expander-supplied slot inputs
   input wire logic [gpa_pkg::HP_GROUPS-1:0] exp_slot_en_i,
   input wire logic [gpa_pkg::HP_GROUPS*5-1:0] exp_slot_in_n_i,
   // pin side
   output logic [gpa_pkg::PIN_COUNT-1:0] alt_val_o,
   output logic [gpa_pkg::PIN_COUNT-1:0] alt_oe_o,
   // core-side alternate inputs
   output logic [gpa_pkg::PART_COUNT-1:0] partition_reset_n_o,
   output logic expander_interrupt_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_attention_button_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_presence_detect_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_power_fault_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_power_good_n_o,
   output logic [gpa_pkg::HP_GROUPS-1:0] slot_retention_latch_n_o
);
   import gpa_pkg::*;

   function automatic int hp_grp(input int p);
      return (p - HP_BASE) / HP_GROUP_PINS;
   endfunction

   function automatic int hp_off(input int p);
      return (p - HP_BASE) % HP_GROUP_PINS;
   endfunction

   // pins without a signal on the chosen function stay undriven
   always_comb begin
      alt_val_o = '1;
      alt_oe_o = '0;
      for (int p = 0; p < PIN_COUNT; p++) begin
         if (!alt_sel_i[p]) begin
            if (p < PART_COUNT) begin
               // open-drain style: pull low only while resetting
               alt_val_o[p] = 1'b0;
               alt_oe_o[p] = ~partition_drive_n_i[p];
            end else if (p == GPE_PIN) begin
               alt_val_o[p] = general_event_out_n_i;
               alt_oe_o[p] = 1'b1;
            end else if (p >= HP_BASE && hp_off(p) >= HP_IN_COUNT) begin
               alt_oe_o[p] = 1'b1;
               if (hp_off(p) == HP_AI_OFF) begin
                  alt_val_o[p] = slot_attention_indicator_n_i[hp_grp(p)];
               end else if (hp_off(p) == HP_PI_OFF) begin
                  alt_val_o[p] = slot_power_indicator_n_i[hp_grp(p)];
               end else if (hp_off(p) == HP_PEP_OFF) begin
                  alt_val_o[p] = slot_power_enable_i[hp_grp(p)];
               end else begin
                  alt_val_o[p] = slot_reset_n_i[hp_grp(p)];
               end
            end
         end else if (p == P0_UP_PIN) begin
            alt_val_o[p] = ~port_link_up_i[0];
            alt_oe_o[p] = 1'b1;
         end else if (p == P0_ACT_PIN) begin
            alt_val_o[p] = ~port_link_active_i[0];
            alt_oe_o[p] = 1'b1;
         end else if (p >= LINK_BASE_PIN && p <= LINK_LAST_PIN) begin
            alt_oe_o[p] = 1'b1;
            if ((p - LINK_BASE_PIN) % 2 == 0) begin
               alt_val_o[p] = ~port_link_up_i[(p - LINK_BASE_PIN) / 2 + 1];
            end else begin
               alt_val_o[p] =
                  ~port_link_active_i[(p - LINK_BASE_PIN) / 2 + 1];
            end
         end
      end
   end

   always_comb begin
      logic v;
      v = 1'b1;
      partition_reset_n_o = '1;
      for (int k = 0; k < PART_COUNT; k++) begin
         if (func_i[k] && !alt_sel_i[k]) begin
            partition_reset_n_o[k] = level_i[k];
         end
      end
      expander_interrupt_n_o = 1'b1;
      if (func_i[EXPINT_PIN] && !alt_sel_i[EXPINT_PIN]) begin
         expander_interrupt_n_o = level_i[EXPINT_PIN];
      end
      slot_attention_button_n_o = '1;
      slot_presence_detect_n_o = '1;
      slot_power_fault_n_o = '1;
      slot_power_good_n_o = '1;
      slot_retention_latch_n_o = '1;
      for (int g = 0; g < HP_GROUPS; g++) begin
         for (int o = 0; o < HP_IN_COUNT; o++) begin
            // a pin mapping wins over the expander; with neither, inactive
            v = exp_slot_en_i[g] ? exp_slot_in_n_i[g * HP_IN_COUNT + o] : 1'b1;
            if (func_i[HP_BASE + g * HP_GROUP_PINS + o] &&
                !alt_sel_i[HP_BASE + g * HP_GROUP_PINS + o]) begin
               v = level_i[HP_BASE + g * HP_GROUP_PINS + o];
            end
            if (o == 0) begin
               slot_attention_button_n_o[g] = v;
            end else if (o == 1) begin
               slot_presence_detect_n_o[g] = v;
            end else if (o == 2) begin
               slot_power_fault_n_o[g] = v;
            end else if (o == 3) begin
               slot_power_good_n_o[g] = v;
            end else begin
               slot_retention_latch_n_o[g] = v;
            end
         end
      end
   end
endmodule // gpa_alt_map

// ===== test/gpa_board.sv
/*
 board model for the pin port: resolves each pin wire.
 assumes the port's drive, when enabled, beats the weak board drive.
*/
`timescale 1ns/1ps
module gpa_board (
   // port drive
   input wire logic [gpa_pkg::PIN_COUNT-1:0] drv_i,
   input wire logic [gpa_pkg::PIN_COUNT-1:0] oe_n_i,
   // board side
   input wire logic [gpa_pkg::PIN_COUNT-1:0] board_i,
   output logic [gpa_pkg::PIN_COUNT-1:0] level_o
);
   // released pins show the board value, never the last drive
   assign level_o = (oe_n_i & board_i) | (~oe_n_i & drv_i);
endmodule // gpa_board

// ===== test/testbench.sv
/*
 self-checking bench for the pin port: registers, pins, alternates.
 assumes the single-cycle register port and the board model.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
   miscompares++; $display("[FAIL] %0t got=%h exp=%h", $time, g, e); \
   end end
module testbench;
   import gpa_pkg::*;
   logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [REG_W-1:0] wdata_i = '0, rdata_o, d;
   logic [PIN_COUNT-1:0] pin_o, oe_n, lvl, board = '0;
   logic [3:0] part_n = 4'hf, prst_n;
   logic [15:0] lup = '0, lact = '0;
   logic [4:0] exp_en = '0, ai_n = 5'h1f, btn_n;
   logic [24:0] exp_in = '1;
   logic gpe_n = 1'b1;
   wire [4:0] pd_n, pf_n, pg_n, ml_n;
   wire expint_n;
   int miscompares = 0, num_checks = 0;
   gpa_board board_m (.drv_i(pin_o), .oe_n_i(oe_n), .board_i(board),
      .level_o(lvl));
   gpa_port dut (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .pin_i(lvl), .pin_o, .pin_oe_n_o(oe_n),
      .partition_drive_n_i(part_n), .general_event_out_n_i(gpe_n),
      .slot_attention_indicator_n_i(ai_n),
      .slot_power_indicator_n_i(5'h1f), .slot_power_enable_i(5'h00),
      .slot_reset_n_i(5'h1f), .port_link_up_i(lup),
      .port_link_active_i(lact), .exp_slot_en_i(exp_en),
      .exp_slot_in_n_i(exp_in), .partition_reset_n_o(prst_n),
      .expander_interrupt_n_o(expint_n), .slot_attention_button_n_o(btn_n),
      .slot_presence_detect_n_o(pd_n), .slot_power_fault_n_o(pf_n),
      .slot_power_good_n_o(pg_n), .slot_retention_latch_n_o(ml_n));
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clock_i);
      wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge clock_i);
      rd_i <= 1'b1; addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      // data stand only in the cycle after the strobe edge
      @(posedge clock_i);
      v = rdata_o;
   endtask
   task automatic t_reset();
      for (int a = 0; a < 8; a++) begin
         rd(5'(a * 4), d);
         `CHK(d, 32'h0000_0000)
      end
      rd(5'h02, d);
      `CHK(d, 32'h0000_0000)
      `CHK(oe_n, {PIN_COUNT{1'b1}})
      `CHK(prst_n, 4'hf)
      wr(OFF_ALT_HI, 32'hFFFF_FFFF);
      rd(OFF_ALT_HI, d);
      `CHK(d, 32'h003F_FFFF)
      wr(OFF_FUNC_HI, 32'hFFC0_0000);
      rd(OFF_FUNC_HI, d);
      `CHK(d, 32'h0000_0000)
      wr(OFF_ALT_HI, 32'h0000_0000);
   endtask
   task automatic t_input();
      board <= 54'h2A_5A5A_C3C3_0FF0;
      exp_en <= 5'h01; exp_in <= 25'h1FF_FFE0;
      repeat (12) @(posedge clock_i);
      rd(OFF_DATA_LO, d);
      `CHK(d, 32'hC3C3_0FF0)
      rd(OFF_DATA_HI, d);
      `CHK(d, 32'h002A_5A5A)
      `CHK({btn_n, pd_n, pf_n, pg_n, ml_n}, {5{5'h1e}})
   endtask
   task automatic t_output();
      wr(OFF_DIR_LO, 32'hFFFF_FFFF);
      repeat (2) @(posedge clock_i);
      // the level captured while input is what the pins now drive
      `CHK(pin_o[31:0], 32'hC3C3_0FF0)
      wr(OFF_DATA_LO, 32'h1234_5678);
      repeat (2) @(posedge clock_i);
      `CHK(oe_n[31:0], 32'h0000_0000)
      `CHK(pin_o[31:0], 32'h1234_5678)
      repeat (12) @(posedge clock_i);
      rd(OFF_DATA_LO, d);
      `CHK(d, 32'h1234_5678)
      wr(OFF_DIR_LO, 32'h0000_0000);
   endtask
   task automatic t_alt();
      part_n <= 4'he; lup <= 16'h0002; board <= '0;
      gpe_n <= 1'b0; ai_n <= 5'h1e;
      wr(OFF_FUNC_LO, 32'h0040_4123);
      repeat (2) @(posedge clock_i);
      `CHK({oe_n[5], pin_o[5]}, 2'b00)
      `CHK({oe_n[14], pin_o[14]}, 2'b00)
      wr(OFF_ALT_LO, 32'h0040_0020);
      repeat (3) @(posedge clock_i);
      `CHK({oe_n[1:0], pin_o[0]}, 3'b100)
      `CHK({oe_n[22], pin_o[22]}, 2'b00)
      `CHK({oe_n[5], pin_o[5]}, 2'b01)
      repeat (12) @(posedge clock_i);
      `CHK(prst_n, 4'hc)
      `CHK(expint_n, 1'b0)
      wr(OFF_ALT_LO, 32'h0000_0020);
      repeat (3) @(posedge clock_i);
      `CHK(oe_n[22], 1'b1)
   endtask
   task automatic t_rereset();
      rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      `CHK(oe_n, {PIN_COUNT{1'b1}})
      rd(OFF_FUNC_LO, d);
      `CHK(d, 32'h0000_0000)
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #200us;
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset();
      t_input();
      t_output();
      t_alt();
      t_rereset();
      give_verdict();
   end
endmodule // testbench
